// >>> isg_pkg.sv
// isg_pkg: shared constants, carrier types and helpers for the image statistics block
// assumes a single core clock domain; nothing else is needed
`default_nettype none

package isg_pkg;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0] ISG_ADDR_SHUT_HIGH = 8'h06;
    localparam logic [7:0] ISG_ADDR_SHUT_LOW = 8'h07;
    localparam logic [7:0] ISG_ADDR_PEAK = 8'h08;
    localparam logic [7:0] ISG_ADDR_SUM = 8'h09;
    localparam logic [7:0] ISG_ADDR_FLOOR = 8'h0A;
    localparam logic [7:0] ISG_ADDR_DUMP = 8'h0B;

    // ****************************************************************
    // reset values and field layout
    // ****************************************************************
    localparam logic [15:0] ISG_SHUT_RESET = 16'h0100;
    localparam logic [7:0] ISG_STAT_RESET = 8'h00;
    localparam int ISG_DUMP_VALID_BIT = 7;
    localparam int ISG_SUM_LSB = 9;
    localparam int ISG_SUM_MSB = 16;

    // ****************************************************************
    // value ranges and array geometry
    // ****************************************************************
    localparam logic [7:0] ISG_PIX_CLAMP = 8'hFE;
    localparam logic [16:0] ISG_SUM_CAP = 17'h1E038;
    localparam logic [7:0] ISG_SUM_REG_MAX = 8'hF0;
    localparam logic [8:0] ISG_LAST_IDX = 9'h168;

    // ****************************************************************
    // shutter control loop limits
    // ****************************************************************
    localparam logic [7:0] ISG_PEAK_HIGH = 8'hF0;
    localparam logic [7:0] ISG_PEAK_LOW = 8'h80;
    localparam logic [7:0] ISG_AVG_HIGH = 8'hB4;
    localparam logic [15:0] ISG_SHUT_MIN = 16'h0010;
    localparam logic [15:0] ISG_SHUT_MAX = 16'hFF00;
    localparam logic [15:0] ISG_SHUT_STEP = 16'h0010;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic last;
        logic [7:0] value;
    } isg_pix_t;

    typedef struct packed {
        logic [7:0] peak;
        logic [7:0] floor;
        logic [16:0] sum;
    } isg_stats_t;

    typedef enum logic [1:0] {
        ISG_SHUT_HOLD = 2'b00,
        ISG_SHUT_UP = 2'b01,
        ISG_SHUT_DOWN = 2'b10
    } isg_shut_dir_t;

    typedef enum logic {
        ISG_GRAB_WAIT = 1'b0,
        ISG_GRAB_HELD = 1'b1
    } isg_grab_st_t;

    // limit a raw pixel to the reportable range
    function automatic logic [7:0] isg_clamp_pix(input logic [7:0] raw);
        isg_clamp_pix = (raw > ISG_PIX_CLAMP) ? ISG_PIX_CLAMP : raw;
    endfunction : isg_clamp_pix

endpackage : isg_pkg

`default_nettype wire

// >>> isg_pix_buf.sv
// isg_pix_buf: two-entry buffer for the pixel stream
// assumes both sides use valid and ready on core_clk
`default_nettype none

module isg_pix_buf
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // filling side
    input wire isg_pkg::isg_pix_t in_data,
    input wire logic in_valid,
    output logic in_ready,
    // draining side
    output isg_pkg::isg_pix_t out_data,
    output logic out_valid,
    input wire logic out_ready
);
    import isg_pkg::*;

    isg_pix_t mem_q [2];
    isg_pix_t mem_d [2];
    logic wr_ptr_q;
    logic wr_ptr_d;
    logic rd_ptr_q;
    logic rd_ptr_d;
    logic [1:0] count_q;
    logic [1:0] count_d;
    logic push;
    logic pop;

    assign in_ready = (count_q != 2'h2);
    assign out_valid = (count_q != 2'h0);
    assign out_data = mem_q[rd_ptr_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // ****************************************************************
    // storage entries
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_entry
            always_comb
            begin
                mem_d[gi] = mem_q[gi];
                if (push && (wr_ptr_q == 1'(gi)))
                begin
                    mem_d[gi] = in_data;
                end
            end

            always_ff @(posedge core_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    mem_q[gi] <= '0;
                end
                else
                begin
                    mem_q[gi] <= mem_d[gi];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // pointers and fill level
    // ****************************************************************
    always_comb
    begin
        wr_ptr_d = push ? ~wr_ptr_q : wr_ptr_q;
        rd_ptr_d = pop ? ~rd_ptr_q : rd_ptr_q;
        count_d = count_q;
        if (push && !pop)
        begin
            count_d = count_q + 2'h1;
        end
        else if (pop && !push)
        begin
            count_d = count_q - 2'h1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'h0;
        end
        else
        begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q <= count_d;
        end
    end

endmodule : isg_pix_buf

`default_nettype wire

// >>> isg_frame_stats.sv
// isg_frame_stats: running peak, floor and sum over one frame of pixels
// assumes the frame's final pixel carries the last flag
`default_nettype none

module isg_frame_stats
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // pixel beats
    input wire isg_pkg::isg_pix_t pix,
    input wire logic pix_valid,
    output logic pix_ready,
    // frame result
    output isg_pkg::isg_stats_t stats,
    output logic stats_done
);
    import isg_pkg::*;

    isg_stats_t run_q;
    isg_stats_t run_d;
    isg_stats_t stats_q;
    isg_stats_t stats_d;
    logic done_q;
    logic done_d;
    logic [7:0] val;
    logic [16:0] sum_next;

    // one-cycle bubble while a result is published
    assign pix_ready = !done_q;
    assign stats = stats_q;
    assign stats_done = done_q;
    assign val = isg_clamp_pix(pix.value);

    // ****************************************************************
    // accumulate and publish
    // ****************************************************************
    always_comb
    begin
        run_d = run_q;
        stats_d = stats_q;
        done_d = 1'b0;
        sum_next = run_q.sum + {9'h000, val};
        if (sum_next > ISG_SUM_CAP)
        begin
            sum_next = ISG_SUM_CAP;
        end
        if (pix_valid && pix_ready)
        begin
            run_d.peak = (val > run_q.peak) ? val : run_q.peak;
            run_d.floor = (val < run_q.floor) ? val : run_q.floor;
            run_d.sum = sum_next;
            if (pix.last)
            begin
                stats_d = run_d;
                done_d = 1'b1;
                run_d.peak = 8'h00;
                run_d.floor = ISG_PIX_CLAMP;
                run_d.sum = 17'h00000;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run_q <= '{peak: 8'h00, floor: ISG_PIX_CLAMP, sum: 17'h00000};
            stats_q <= '0;
            done_q <= 1'b0;
        end
        else
        begin
            run_q <= run_d;
            stats_q <= stats_d;
            done_q <= done_d;
        end
    end

endmodule : isg_frame_stats

`default_nettype wire

// >>> isg_image_stats.sv
// isg_image_stats: frame statistics, auto shutter and pixel grabber registers
// assumes a decoded register port and a pixel stream in index order, last flag on pixel 360
//
// Behaviour
// - the shutter time is a sixteen-bit value whose low byte reads at 0x07.
// - the shutter time is counted in internal clock cycles.
// - the shutter is adjusted automatically to keep average and peak pixel levels in range.
// - the peak register holds the highest pixel of the last frame, from 0 to 254.
// - the lowest register holds the smallest pixel of the last frame, from 0 to 254.
// - the sum register reports bits 16 to 9 of the seventeen-bit pixel total.
// - the total never exceeds 122936, so the sum register stays between 0 and 240.
// - the grabber captures at most one pixel per frame, and none while a held sample is unread.
// - the grabber register shows the valid flag in bit 7 and pixel bits 7 to 1 in bits 6 to 0.
// - the array is 19 by 19, so a full dump takes 361 valid reads.
// - any write to the grabber register returns the grab position to index 0.
// - indices run column by column, 19 per column, from 0 to 360.
// - the shutter high byte reads at 0x06 and resets to 0x01.
`default_nettype none

module isg_image_stats
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // pixel stream from image capture
    input wire isg_pkg::isg_pix_t pix_in,
    input wire logic pix_in_valid,
    output logic pix_in_ready,
    // register access
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // exposure control
    output logic [15:0] shutter_time
);
    import isg_pkg::*;

    // ****************************************************************
    // buffer and statistics
    // ****************************************************************
    isg_pix_t buf_data;
    logic buf_valid;
    logic stats_ready;
    isg_stats_t stats;
    logic stats_done;
    logic beat;

    isg_pix_buf isg_pix_buf_inst
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_data(pix_in),
        .in_valid(pix_in_valid),
        .in_ready(pix_in_ready),
        .out_data(buf_data),
        .out_valid(buf_valid),
        .out_ready(stats_ready)
    );

    isg_frame_stats isg_frame_stats_inst
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pix(buf_data),
        .pix_valid(buf_valid),
        .pix_ready(stats_ready),
        .stats(stats),
        .stats_done(stats_done)
    );

    assign beat = buf_valid && stats_ready;

    // ****************************************************************
    // register access decode
    // ****************************************************************
    logic rd_dump;
    logic wr_dump;
    logic rd_shut_high;

    assign rd_dump = reg_rd && (reg_addr == ISG_ADDR_DUMP);
    assign wr_dump = reg_wr && (reg_addr == ISG_ADDR_DUMP);
    assign rd_shut_high = reg_rd && (reg_addr == ISG_ADDR_SHUT_HIGH);

    // ****************************************************************
    // published statistics
    // ****************************************************************
    logic [7:0] peak_q, peak_d;
    logic [7:0] floor_q, floor_d;
    logic [7:0] sum_high_q, sum_high_d;
    logic [7:0] sum_bits;

    assign sum_bits = stats.sum[ISG_SUM_MSB:ISG_SUM_LSB];

    always_comb
    begin
        peak_d = peak_q;
        floor_d = floor_q;
        sum_high_d = sum_high_q;
        if (stats_done)
        begin
            peak_d = isg_clamp_pix(stats.peak);
            floor_d = isg_clamp_pix(stats.floor);
            sum_high_d = (sum_bits > ISG_SUM_REG_MAX) ? ISG_SUM_REG_MAX : sum_bits;
        end
    end
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            peak_q <= ISG_STAT_RESET;
            floor_q <= ISG_STAT_RESET;
            sum_high_q <= ISG_STAT_RESET;
        end
        else
        begin
            peak_q <= peak_d;
            floor_q <= floor_d;
            sum_high_q <= sum_high_d;
        end
    end

    // ****************************************************************
    // automatic shutter
    // ****************************************************************
    logic [15:0] shut_q, shut_d;
    logic [7:0] low_latch_q, low_latch_d;
    isg_shut_dir_t dir;

    assign shutter_time = shut_q;

    always_comb
    begin
        dir = ISG_SHUT_HOLD;
        if (isg_clamp_pix(stats.peak) > ISG_PEAK_HIGH || sum_bits > ISG_AVG_HIGH)
        begin
            dir = ISG_SHUT_DOWN;
        end
        else if (isg_clamp_pix(stats.peak) < ISG_PEAK_LOW)
        begin
            dir = ISG_SHUT_UP;
        end
        shut_d = shut_q;
        if (stats_done)
        begin
            case (dir)
                ISG_SHUT_DOWN:
                    shut_d = (shut_q > ISG_SHUT_MIN + ISG_SHUT_STEP) ? shut_q - ISG_SHUT_STEP : ISG_SHUT_MIN;
                ISG_SHUT_UP:
                    shut_d = (shut_q < ISG_SHUT_MAX - ISG_SHUT_STEP) ? shut_q + ISG_SHUT_STEP : ISG_SHUT_MAX;
                default:
                    shut_d = shut_q;
            endcase
        end
        // low byte frozen at the high byte read
        low_latch_d = rd_shut_high ? shut_q[7:0] : low_latch_q;
    end
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shut_q <= ISG_SHUT_RESET;
            low_latch_q <= ISG_SHUT_RESET[7:0];
        end
        else
        begin
            shut_q <= shut_d;
            low_latch_q <= low_latch_d;
        end
    end

    // ****************************************************************
    // pixel grabber
    // ****************************************************************
    isg_grab_st_t grab_st_q, grab_st_d;
    logic [8:0] pix_idx_q, pix_idx_d;
    logic [8:0] grab_idx_q, grab_idx_d;
    logic [6:0] dump_sample_value_q, dump_sample_value_d;
    logic taken_q, taken_d;
    logic [7:0] grab_pix;
    logic capture;
    logic dump_sample_valid;

    assign dump_sample_valid = (grab_st_q == ISG_GRAB_HELD);
    assign capture = beat && !taken_q && (grab_st_q == ISG_GRAB_WAIT) && (pix_idx_q == grab_idx_q);
    assign grab_pix = isg_clamp_pix(buf_data.value);

    always_comb
    begin
        pix_idx_d = pix_idx_q;
        if (beat)
        begin
            pix_idx_d = (buf_data.last || pix_idx_q == ISG_LAST_IDX) ? 9'h000 : pix_idx_q + 9'h001;
        end
        taken_d = (beat && buf_data.last) ? 1'b0 : (taken_q || capture);
        grab_st_d = grab_st_q;
        grab_idx_d = grab_idx_q;
        dump_sample_value_d = dump_sample_value_q;
        case (grab_st_q)
            ISG_GRAB_WAIT:
            begin
                if (capture)
                begin
                    grab_st_d = ISG_GRAB_HELD;
                    dump_sample_value_d = grab_pix[7:1];
                end
            end
            ISG_GRAB_HELD:
            begin
                if (rd_dump)
                begin
                    grab_st_d = ISG_GRAB_WAIT;
                    grab_idx_d = (grab_idx_q == ISG_LAST_IDX) ? 9'h000 : grab_idx_q + 9'h001;
                end
            end
            default:
                grab_st_d = ISG_GRAB_WAIT;
        endcase
        if (wr_dump)
        begin
            grab_st_d = ISG_GRAB_WAIT;
            grab_idx_d = 9'h000;
        end
    end
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            grab_st_q <= ISG_GRAB_WAIT;
            pix_idx_q <= 9'h000;
            grab_idx_q <= 9'h000;
            dump_sample_value_q <= 7'h00;
            taken_q <= 1'b0;
        end
        else
        begin
            grab_st_q <= grab_st_d;
            pix_idx_q <= pix_idx_d;
            grab_idx_q <= grab_idx_d;
            dump_sample_value_q <= dump_sample_value_d;
            taken_q <= taken_d;
        end
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q;

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;

    always_comb
    begin
        rdata_d = rdata_q;
        if (reg_rd)
        begin
            case (reg_addr)
                ISG_ADDR_SHUT_HIGH: rdata_d = shut_q[15:8];
                ISG_ADDR_SHUT_LOW: rdata_d = low_latch_q;
                ISG_ADDR_PEAK: rdata_d = peak_q;
                ISG_ADDR_SUM: rdata_d = sum_high_q;
                ISG_ADDR_FLOOR: rdata_d = floor_q;
                ISG_ADDR_DUMP: rdata_d = {dump_sample_valid, dump_sample_value_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            rvalid_q <= reg_rd;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    logic seen_frame_q;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            seen_frame_q <= 1'b0;
        else if (stats_done)
            seen_frame_q <= 1'b1;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_dump_write_origin: assert property (wr_dump |=> grab_idx_q == 9'h000 && !dump_sample_valid)
        else $error("grabber write did not return to origin");
    a_dump_read_consume: assert property (rd_dump && dump_sample_valid && !reg_wr |=> !dump_sample_valid
        && grab_idx_q == (($past(grab_idx_q) == ISG_LAST_IDX) ? 9'h000 : $past(grab_idx_q) + 9'h001))
        else $error("grabber read did not consume sample");
    a_dump_rdata_flag: assert property (rd_dump |=> reg_rvalid && reg_rdata[ISG_DUMP_VALID_BIT] == $past(dump_sample_valid))
        else $error("grabber valid flag mismatch");
    a_sum_reg_cap: assert property (sum_high_q <= ISG_SUM_REG_MAX)
        else $error("sum register above cap");
    a_peak_floor_range: assert property (stats_done |=> peak_q <= ISG_PIX_CLAMP && floor_q <= ISG_PIX_CLAMP)
        else $error("peak or floor out of range");
    a_shut_coherent: assert property (rd_shut_high ##1 (reg_rd && reg_addr == ISG_ADDR_SHUT_LOW)
        |=> reg_rdata == $past(shut_q[7:0], 2))
        else $error("shutter low byte not coherent");
    a_shut_step_down: assert property (stats_done && dir == ISG_SHUT_DOWN && shut_q > ISG_SHUT_MIN + ISG_SHUT_STEP
        |=> shut_q == $past(shut_q) - ISG_SHUT_STEP)
        else $error("shutter did not step down");
    a_idx_wrap_last: assert property (beat && pix_idx_q == ISG_LAST_IDX |=> pix_idx_q == 9'h000)
        else $error("pixel index did not wrap");
    a_one_per_frame: assert property (capture && !buf_data.last |=> taken_q && !capture)
        else $error("second capture in one frame");
    a_zero_before_frame: assert property (!seen_frame_q |-> peak_q == 8'h00 && floor_q == 8'h00
        && sum_high_q == 8'h00)
        else $error("statistics nonzero before first frame");

    c_frame_done: cover property (stats_done);
    c_dump_consume: cover property (rd_dump && dump_sample_valid);
    c_dump_origin: cover property (wr_dump && grab_idx_q != 9'h000);
    c_buf_stall: cover property (pix_in_valid && !pix_in_ready);

endmodule : isg_image_stats

`default_nettype wire

// >>> isg_pix_src.sv
// isg_pix_src: image capture model feeding one frame of pixels per start request
// assumes valid/ready on core_clk; drives at the falling edge
`default_nettype none

module isg_pix_src
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // frame request
    input wire logic start,
    output logic busy,
    // pixel stream
    output isg_pkg::isg_pix_t pix,
    output logic pix_valid,
    input wire logic pix_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    import isg_pkg::*;
    logic [8:0] idx;
    logic taken;
    logic go;
    initial
    begin
        busy = 1'b0;
        pix_valid = 1'b0;
        idx = 9'h000;
        pix = '0;
    end
    always @(posedge core_clk)
    begin
        taken <= pix_valid && pix_ready;
        go <= start && rst_n;
    end
    always @(negedge core_clk)
    begin
        if (go && !busy)
        begin
            busy = 1'b1;
            idx = 9'h000;
            pix_valid = 1'b1;
        end
        else if (taken && busy)
        begin
            if (idx == 9'h168)
            begin
                busy = 1'b0;
                pix_valid = 1'b0;
                // released bus shows the inverse of its last value
                pix = ~pix;
            end
            else
            begin
                idx = idx + 9'h001;
            end
        end
        if (pix_valid)
        begin
            pix.last = (idx == 9'h168);
            pix.value = (idx == 9'h001) ? 8'h60 : (idx == 9'h005) ? 8'hFF : (idx == 9'h007) ? 8'h03 : 8'h40;
        end
    end
endmodule : isg_pix_src

`default_nettype wire

// >>> isg_image_stats_tb.sv
// isg_image_stats_tb: register and frame scenarios for the statistics block
// assumes isg_pix_src as the pixel source; stimulus at the falling edge
`default_nettype none

module isg_image_stats_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import isg_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    logic busy;
    isg_pix_t pix_in;
    logic pix_in_valid;
    logic pix_in_ready;
    logic [7:0] reg_addr = 8'h00;
    logic reg_rd = 1'b0;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic [15:0] shutter_time;
    int err_total = 0;
    int n_compared = 0;
    logic [7:0] last_rd = 8'h00;

    always #25 core_clk = ~core_clk;

    isg_image_stats isg_image_stats_inst (.core_clk(core_clk), .rst_n(rst_n), .pix_in(pix_in),
        .pix_in_valid(pix_in_valid), .pix_in_ready(pix_in_ready), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .shutter_time(shutter_time));
    isg_pix_src isg_pix_src_inst (.core_clk(core_clk), .rst_n(rst_n), .start(start), .busy(busy),
        .pix(pix_in), .pix_valid(pix_in_valid), .pix_ready(pix_in_ready));

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    task automatic rdc(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
        int k;
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        for (k = 0; k < 4 && reg_rvalid !== 1'b1; k++)
            @(negedge core_clk);
        chk({8'h00, reg_rvalid}, 16'h0001, "read answer");
        chk({8'h00, reg_rdata & mask}, {8'h00, exp}, $sformatf("read of %h", a));
        last_rd = reg_rdata;
    endtask : rdc

    // high byte then low byte in consecutive cycles
    task automatic rd_shut(input logic [15:0] exp);
        @(negedge core_clk);
        reg_addr = ISG_ADDR_SHUT_HIGH;
        reg_rd = 1'b1;
        @(negedge core_clk);
        chk({15'h0000, reg_rvalid}, 16'h0001, "high byte answer");
        chk({8'h00, reg_rdata}, {8'h00, exp[15:8]}, "shutter high byte");
        reg_addr = ISG_ADDR_SHUT_LOW;
        @(negedge core_clk);
        reg_rd = 1'b0;
        chk({15'h0000, reg_rvalid}, 16'h0001, "low byte answer");
        chk({8'h00, reg_rdata}, {8'h00, exp[7:0]}, "shutter low byte");
    endtask : rd_shut

    task automatic wr(input logic [7:0] a);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = 8'h5A;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic frame();
        int k;
        @(negedge core_clk);
        start = 1'b1;
        for (k = 0; k < 10 && busy !== 1'b1; k++)
            @(posedge core_clk);
        @(negedge core_clk);
        start = 1'b0;
        for (k = 0; k < 2000 && busy !== 1'b0; k++)
            @(posedge core_clk);
        chk({15'h0000, busy}, 16'h0000, "frame finished");
        repeat (6) @(posedge core_clk);
    endtask : frame

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset();
        chk(shutter_time, 16'h0100, "shutter at reset");
        chk({15'h0000, pix_in_ready}, 16'h0001, "pixel ready at reset");
        rdc(8'h06, 8'hFF, 8'h01);
        rdc(8'h07, 8'hFF, 8'h00);
        rdc(8'h08, 8'hFF, 8'h00);
        rdc(8'h09, 8'hFF, 8'h00);
        rdc(8'h0A, 8'hFF, 8'h00);
        rdc(8'h0B, 8'hFF, 8'h00);
        $display("test reset values done");
    endtask : t_reset

    task automatic t_frame_one();
        frame();
        rdc(8'h08, 8'hFF, 8'hFE);
        rdc(8'h0A, 8'hFF, 8'h03);
        rdc(8'h09, 8'hFF, 8'h2D);
        chk(16'(int'(last_rd * 1.058)), 16'h0030, "average from sum register");
        wr(8'h09);
        rdc(8'h09, 8'hFF, 8'h2D);
        rdc(8'h0C, 8'hFF, 8'h00);
        chk(shutter_time, 16'h00F0, "shutter after bright frame");
        rd_shut(16'h00F0);
        rdc(8'h0B, 8'hFF, 8'hA0);
        rdc(8'h0B, 8'h80, 8'h00);
        $display("test first frame done");
    endtask : t_frame_one

    task automatic t_grab_walk();
        frame();
        rdc(8'h0B, 8'hFF, 8'hB0);
        wr(8'h0B);
        frame();
        rdc(8'h0B, 8'hFF, 8'hA0);
        rdc(8'h0B, 8'h80, 8'h00);
        chk(shutter_time, 16'h00D0, "shutter after three frames");
        rd_shut(16'h00D0);
        $display("test grabber walk done");
    endtask : t_grab_walk

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    initial
    begin
        repeat (6) @(negedge core_clk);
        rst_n = 1'b1;
        t_reset();
        t_frame_one();
        t_grab_walk();
        results();
    end

    initial
    begin
        #500000;
        err_total++;
        results();
    end
endmodule : isg_image_stats_tb

`default_nettype wire
